// [verilog/epd_defs.svh]
// Constants for the extended pointer instruction decoder
`ifndef EPD_DEFS_SVH
`define EPD_DEFS_SVH
`define EPD_OP_HI_EXT 8'hE8
`define EPD_OP_ADD_PTR 8'hE8
`define EPD_OP_SUB_PTR 8'hE9
`define EPD_OP_PUSH_LIT 8'hEA
`define EPD_OP_MOVE_IDX 8'hEB
`define EPD_OP_CALL_W 16'h0014
`define EPD_SECOND_NIBBLE 4'hF
`define EPD_SEL_FRAME 2'h3
`define EPD_PTR_RESET 12'h000
`define EPD_PC_RESET 21'h000000
`define EPD_PC_STEP 21'h000002
`endif

// [verilog/epd_pkg.sv]
// Types shared by the extended pointer instruction decoder
package epd_pkg;
  typedef enum logic [1:0] {
    EPD_ST_FETCH = 2'b00,
    EPD_ST_NOP = 2'b01,
    EPD_ST_SECOND = 2'b10
  } epd_state_e;
  // One data memory access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } epd_mem_s;
  // Program counter load request
  typedef struct packed {
    logic load;
    logic push;
    logic [20:0] target;
    logic [20:0] ret_addr;
  } epd_pc_s;
endpackage

// [verilog/epd_ptr_alu.sv]
// Wrapping add or subtract of a literal on a 12-bit pointer
`timescale 1ns/1ps
module epd_ptr_alu #(
  parameter int W = 12
) (
  // Operands
  input wire logic [W-1:0] ptr,
  input wire logic [6:0] lit,
  input wire logic sub,
  // Result
  output logic [W-1:0] res
);
  // Elaboration check: the literal needs seven bits of room
  if (W < 7) begin : g_bad_w
    $error("epd_ptr_alu: width too small");
  end
  // Carry or borrow is dropped on purpose
  assign res = sub ? W'(ptr - W'(lit)) : W'(ptr + W'(lit));
endmodule // epd_ptr_alu

// [verilog/epd_decoder.sv]
// Decode and execute of the eight extension instructions
//
// Contract
// - Add 6-bit literal to selected pointer, one cycle, flags untouched.
// - Add-and-return adds literal to frame pointer then loads PC from stack top.
// - Add-and-return is add encoding with select field 11.
// - Add-and-return takes two cycles; second cycle is a no-op.
// - Call-via-working-reg is word 0014h, two cycles, flags untouched.
// - Call pushes next address, PC from working reg and latches.
// - Move indexed to file: two words, 7-bit source, 12-bit destination.
// - Move indexed to indexed: two words, destination offset, x bits ignored.
// - Indexed address is frame pointer plus 7-bit offset, 12-bit space.
// - Push literal writes at frame pointer then decrements it, one cycle.
// - Subtract 6-bit literal from selected pointer, one cycle.
// - Subtract-and-return on frame pointer, two cycles, PC from stack top.
// - Add-and-return touches only frame pointer and PC.
// - Extensions start only while extended set enable is high; a move already begun takes its second word regardless.
`timescale 1ns/1ps
`include "epd_defs.svh"
module epd_decoder #(
  parameter int PTR_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction stream from fetch
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic extended_set_enable,
  // Core state inputs
  input wire logic [20:0] pc_next,
  input wire logic [20:0] return_stack_top,
  input wire logic [7:0] working_register,
  input wire logic [7:0] pc_latch_high,
  input wire logic [4:0] pc_latch_upper,
  input wire logic [7:0] mem_rdata,
  // Decode results
  output logic ext_hit,
  output logic stall_fetch,
  output logic [PTR_W-1:0] ptr0,
  output logic [PTR_W-1:0] ptr1,
  output logic [PTR_W-1:0] stack_frame_pointer,
  output epd_pkg::epd_mem_s mem_req,
  output epd_pkg::epd_pc_s pc_req
);
  // Elaboration check: the encodings only carry a 12-bit address
  if (PTR_W != 12) begin : g_bad_ptr_w
    $error("epd_decoder: pointer width must be 12");
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic is_op(input logic [15:0] w, input logic [7:0] op);
    is_op = (w[15:8] == op);
  endfunction

  // Select value 11 names the frame pointer and the return forms
  function automatic logic is_frame_sel(input logic [1:0] s);
    is_frame_sel = (s == `EPD_SEL_FRAME);
  endfunction

  epd_pkg::epd_state_e state_reg;
  logic [PTR_W-1:0] ptr_reg [0:2];
  logic [15:0] first_reg;
  logic is_ret;
  logic first_indexed;
  logic [PTR_W-1:0] idx_addr;
  logic take;
  logic [1:0] sel;
  logic [6:0] lit6;
  logic is_add;
  logic is_sub;
  logic is_push;
  logic is_move;
  logic is_call;
  logic [PTR_W-1:0] alu_in;
  logic [PTR_W-1:0] alu_out;

  // Extensions decoded only in fetch state with enable high
  assign take = instr_valid && extended_set_enable && (state_reg == epd_pkg::EPD_ST_FETCH);
  assign sel = instr_word[7:6];
  assign lit6 = {1'b0, instr_word[5:0]};
  assign is_add = take && is_op(instr_word, `EPD_OP_ADD_PTR);
  assign is_sub = take && is_op(instr_word, `EPD_OP_SUB_PTR);
  assign is_push = take && is_op(instr_word, `EPD_OP_PUSH_LIT);
  assign is_move = take && is_op(instr_word, `EPD_OP_MOVE_IDX);
  assign is_call = take && (instr_word == `EPD_OP_CALL_W);
  // Return forms share one decode; they add the idle second cycle
  assign is_ret = (is_add || is_sub) && is_frame_sel(sel);
  // Frame-relative address; both words keep their offset in the low seven bits
  assign idx_addr = PTR_W'(ptr_reg[2] + PTR_W'(instr_word[6:0]));
  // Bit 7 of the held first word picks an indexed destination
  assign first_indexed = first_reg[7];

  // Select 11 maps onto the frame pointer for the return forms
  assign alu_in = ptr_reg[is_frame_sel(sel) ? 2'd2 : sel];

  epd_ptr_alu #(.W(PTR_W)) u_alu (
    .ptr(alu_in),
    .lit(lit6),
    .sub(is_sub),
    .res(alu_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: one-cycle ops stay in fetch, others add a cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= epd_pkg::EPD_ST_FETCH;
      first_reg <= 16'h0000;
    end else begin
      case (state_reg)
        epd_pkg::EPD_ST_FETCH: begin
          if (is_ret) begin
            state_reg <= epd_pkg::EPD_ST_NOP;
          end else if (is_call) begin
            state_reg <= epd_pkg::EPD_ST_NOP;
          end else if (is_move) begin
            state_reg <= epd_pkg::EPD_ST_SECOND;
            first_reg <= instr_word;
          end
        end
        epd_pkg::EPD_ST_NOP: begin
          // Idle second cycle of a return or call; the word on offer is dropped
          state_reg <= epd_pkg::EPD_ST_FETCH;
        end
        epd_pkg::EPD_ST_SECOND: begin
          // Waits for the second word from fetch; a bubble keeps the move pending,
          // so the source byte must still stand on mem_rdata when that word arrives
          if (instr_valid) state_reg <= epd_pkg::EPD_ST_FETCH;
        end
        default: state_reg <= epd_pkg::EPD_ST_FETCH;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointer registers; status flags are never written here
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          ptr_reg[gi] <= `EPD_PTR_RESET;
        end else if ((is_add || is_sub) &&
                     (sel == 2'(gi) || (gi == 2 && is_frame_sel(sel)))) begin
          ptr_reg[gi] <= alu_out;
          // Push never shares a cycle with add or subtract, so this order is free
        end else if (gi == 2 && is_push) begin
          ptr_reg[gi] <= PTR_W'(ptr_reg[gi] - 1'b1);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Data memory traffic for push and indexed moves
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_req <= '0;
    end else begin
      mem_req <= '0;
      if (is_push) begin
        // Byte lands at the old frame pointer while the decrement runs alongside
        mem_req.wr <= 1'b1;
        mem_req.addr <= ptr_reg[2];
        mem_req.wdata <= instr_word[7:0];
      end else if (is_move) begin
        // Source read issued in first cycle
        mem_req.rd <= 1'b1;
        mem_req.addr <= idx_addr;
      end else if (state_reg == epd_pkg::EPD_ST_SECOND && instr_valid) begin
        mem_req.wr <= 1'b1;
        mem_req.wdata <= mem_rdata;
        if (first_indexed) begin
          // X bits of the second word are ignored
          mem_req.addr <= idx_addr;
        end else begin
          mem_req.addr <= instr_word[11:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter requests for call and the return forms
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pc_req <= '0;
    end else begin
      pc_req <= '0;
      if (is_ret) begin
        pc_req.load <= 1'b1;
        pc_req.target <= return_stack_top;
      end else if (is_call) begin
        pc_req.load <= 1'b1;
        pc_req.push <= 1'b1;
        pc_req.ret_addr <= pc_next;
        pc_req.target <= {pc_latch_upper, pc_latch_high, working_register};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs, all registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_hit <= 1'b0;
      stall_fetch <= 1'b0;
    end else begin
      // A move counts once, on its first word; the second word is not a new hit
      ext_hit <= is_add || is_sub || is_push || is_move || is_call;
      stall_fetch <= is_ret || is_call;
    end
  end

  // Pointers leave straight from their flip-flops
  assign ptr0 = ptr_reg[0];
  assign ptr1 = ptr_reg[1];
  assign stack_frame_pointer = ptr_reg[2];
endmodule // epd_decoder

// [testbench/epd_props.sv]
// Checker bound to the extended pointer decoder
`timescale 1ns/1ps
module epd_props #(
  parameter int PTR_W = 12
) (
  // Clock, reset and inputs
  input wire logic clk,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic extended_set_enable,
  input wire logic [20:0] pc_next,
  input wire logic [20:0] return_stack_top,
  input wire logic [7:0] working_register,
  input wire logic [7:0] pc_latch_high,
  input wire logic [4:0] pc_latch_upper,
  input wire logic [7:0] mem_rdata,
  // Outputs
  input wire logic ext_hit,
  input wire logic stall_fetch,
  input wire logic [PTR_W-1:0] ptr0,
  input wire logic [PTR_W-1:0] stack_frame_pointer,
  input wire epd_pkg::epd_mem_s mem_req,
  input wire epd_pkg::epd_pc_s pc_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] word_reg;
  logic go;
  // Last word, so checks one cycle on see the operands
  always_ff @(posedge clk) word_reg <= instr_word;
  // Word taken in fetch state
  assign go = instr_valid && extended_set_enable && !stall_fetch && !mem_req.rd;
  a_add_ptr: assert property (go && instr_word[15:6] == 10'h3A0 |=> ptr0 == $past(ptr0) + word_reg[5:0])
    else $error("bad pointer add");
  a_sub_ptr: assert property (go && instr_word[15:6] == 10'h3A4 |=> ptr0 == $past(ptr0) - word_reg[5:0])
    else $error("bad pointer subtract");
  a_sub_ret: assert property (go && instr_word[15:6] == 10'h3A7 |=> pc_req.load && $stable(ptr0)
    && pc_req.target == $past(return_stack_top) && stack_frame_pointer == $past(stack_frame_pointer) - word_reg[5:0])
    else $error("bad subtract and return");
  a_add_ret: assert property (go && instr_word[15:6] == 10'h3A3 |=> pc_req.load && $stable(ptr0)
    && pc_req.target == $past(return_stack_top) && stack_frame_pointer == $past(stack_frame_pointer) + word_reg[5:0])
    else $error("bad add and return");
  a_ret_idle: assert property (pc_req.load |-> stall_fetch ##1 !pc_req.load && !ext_hit)
    else $error("second cycle not idle");
  a_call_target: assert property (go && instr_word == 16'h0014 |=> pc_req.push && pc_req.ret_addr == $past(pc_next)
    && pc_req.target == {$past(pc_latch_upper), $past(pc_latch_high), $past(working_register)})
    else $error("bad call target");
  a_push_lit: assert property (go && instr_word[15:8] == 8'hEA |=> mem_req.wr && mem_req.wdata == word_reg[7:0]
    && mem_req.addr == $past(stack_frame_pointer) && stack_frame_pointer == $past(stack_frame_pointer) - 1'b1)
    else $error("bad push");
  a_move_src: assert property (go && instr_word[15:8] == 8'hEB |=> mem_req.rd
    && mem_req.addr == $past(stack_frame_pointer) + word_reg[6:0])
    else $error("bad source address");
  a_move_file: assert property (mem_req.rd && instr_valid && !word_reg[7] |=> mem_req.wr
    && mem_req.addr == word_reg[11:0] && mem_req.wdata == $past(mem_rdata))
    else $error("bad file move");
  a_move_index: assert property (mem_req.rd && instr_valid && word_reg[7] |=> mem_req.wr
    && mem_req.addr == $past(stack_frame_pointer) + word_reg[6:0] && mem_req.wdata == $past(mem_rdata))
    else $error("bad indexed move");
  a_ext_off: assert property (instr_valid && !extended_set_enable && !stall_fetch && !mem_req.rd
    |=> !ext_hit && !pc_req.load && !mem_req.wr && $stable(ptr0))
    else $error("acted while disabled");
endmodule // epd_props
bind epd_decoder epd_props #(.PTR_W(PTR_W)) i_epd_props (
  .clk(clk),
  .rst_b(rst_b),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .extended_set_enable(extended_set_enable),
  .pc_next(pc_next),
  .return_stack_top(return_stack_top),
  .working_register(working_register),
  .pc_latch_high(pc_latch_high),
  .pc_latch_upper(pc_latch_upper),
  .mem_rdata(mem_rdata),
  .ext_hit(ext_hit),
  .stall_fetch(stall_fetch),
  .ptr0(ptr0),
  .stack_frame_pointer(stack_frame_pointer),
  .mem_req(mem_req),
  .pc_req(pc_req)
);

// [testbench/epd_mem_model.sv]
// Data memory partner for the decoder bench
`timescale 1ns/1ps
module epd_mem_model (
  // Clock
  input wire logic clk,
  // Request and answer
  input wire epd_pkg::epd_mem_s mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last_reg = 8'hA5;
  // Known fill so every read can be predicted
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5A;
  // Idle bus shows the inverse of the last byte, never a stale match
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_reg;
  // Track last byte and store writes
  always @(posedge clk) begin
    last_reg <= mem_rdata;
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule // epd_mem_model

// [testbench/epd_decoder_test.sv]
// Self-checking bench for the extended pointer decoder
`timescale 1ns/1ps
module epd_decoder_test;
  logic clk, rst_b, instr_valid, extended_set_enable, ext_hit, stall_fetch;
  logic [15:0] instr_word;
  logic [20:0] pc_next, return_stack_top;
  logic [7:0] working_register, pc_latch_high, mem_rdata;
  logic [4:0] pc_latch_upper;
  logic [11:0] ptr0, ptr1, stack_frame_pointer;
  epd_pkg::epd_mem_s mem_req;
  epd_pkg::epd_pc_s pc_req;
  int mismatches, total_checks;
  epd_decoder i_epd_decoder (
    .clk(clk),
    .rst_b(rst_b),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .extended_set_enable(extended_set_enable),
    .pc_next(pc_next),
    .return_stack_top(return_stack_top),
    .working_register(working_register),
    .pc_latch_high(pc_latch_high),
    .pc_latch_upper(pc_latch_upper),
    .mem_rdata(mem_rdata),
    .ext_hit(ext_hit),
    .stall_fetch(stall_fetch),
    .ptr0(ptr0),
    .ptr1(ptr1),
    .stack_frame_pointer(stack_frame_pointer),
    .mem_req(mem_req),
    .pc_req(pc_req)
  );
  epd_mem_model i_epd_mem_model (
    .clk(clk),
    .mem_req(mem_req),
    .mem_rdata(mem_rdata)
  );
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [20:0] g, e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Present one word and let its edge land
  task automatic op(input logic [15:0] w);
    instr_valid = 1'b1;
    instr_word = w;
    @(posedge clk);
    #1;
  endtask
  task automatic idle;
    instr_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Back-to-back pointer arithmetic with wrap
  task automatic t_arith;
    op(16'hE83F);
    chk(ptr0, 12'h03F);
    chk(ext_hit, 1'b1);
    op(16'hE93F);
    chk(ptr0, 12'h000);
    op(16'hE901);
    chk(ptr0, 12'hFFF);
    op(16'hE841);
    chk(ptr1, 12'h001);
    op(16'hE8A3);
    chk(stack_frame_pointer, 12'h023);
    idle;
  endtask
  // Returns, with a word offered during the idle cycle
  task automatic t_ret;
    op(16'hE8C5);
    chk(stack_frame_pointer, 12'h028);
    chk(pc_req.target, 21'h012340);
    chk(ptr0, 12'hFFF);
    chk(pc_req.load, 1'b1);
    chk(stall_fetch, 1'b1);
    op(16'hE841);
    chk(ptr1, 12'h001);
    chk(ext_hit, 1'b0);
    chk(pc_req.load, 1'b0);
    op(16'hE9C8);
    chk(stall_fetch, 1'b1);
    chk(stack_frame_pointer, 12'h020);
    chk(pc_req.target, 21'h012340);
    idle;
  endtask
  task automatic t_call;
    op(16'h0014);
    chk(pc_req.target, 21'h011006);
    chk(pc_req.ret_addr, 21'h000102);
    chk(pc_req.push, 1'b1);
    chk(stall_fetch, 1'b1);
    op(16'hE841);
    chk(ptr1, 12'h001);
    idle;
  endtask
  task automatic t_push;
    op(16'hEA55);
    chk(mem_req.addr, 12'h020);
    chk(mem_req.wdata, 8'h55);
    chk(stack_frame_pointer, 12'h01F);
    chk(mem_req.wr, 1'b1);
    idle;
  endtask
  // Both move forms back to back
  task automatic t_move;
    op(16'hEB05);
    chk(mem_req.addr, 12'h024);
    chk(mem_req.rd, 1'b1);
    op(16'hF123);
    chk(mem_req.addr, 12'h123);
    chk(mem_req.wdata, 8'h7E);
    chk(mem_req.wr, 1'b1);
    op(16'hEB87);
    chk(mem_req.addr, 12'h026);
    op(16'hFF86);
    chk(mem_req.addr, 12'h025);
    chk(mem_req.wdata, 8'h7C);
    idle;
  endtask
  task automatic t_off;
    extended_set_enable = 1'b0;
    op(16'hE801);
    chk(ptr0, 12'hFFF);
    chk(ext_hit, 1'b0);
    extended_set_enable = 1'b1;
    idle;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
  // Reset, then the scenarios
  initial begin
    {rst_b, instr_valid, instr_word} = '0;
    extended_set_enable = 1'b1;
    pc_next = 21'h000102;
    return_stack_top = 21'h012340;
    {pc_latch_upper, pc_latch_high, working_register} = 21'h011006;
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_arith;
    t_ret;
    t_call;
    t_push;
    t_move;
    t_off;
    tally_and_finish;
  end
endmodule // epd_decoder_test
